/* src/rltc_pkg.sv */
// ****************************************************************
// Register map and field layout
// ****************************************************************
package rltc_pkg;

  localparam int unsigned RLTC_DATA_W    = 16;
  localparam int unsigned RLTC_LONG2_W   = 24;
  localparam int unsigned RLTC_TICK_W    = 25;
  localparam int unsigned RLTC_L2_HI_W   = 8;
  localparam int unsigned RLTC_TK_HI_W   = 9;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [31:0] RLTC_IDX_L2_PER_LO  = 32'h0B0000D8;
  localparam logic [31:0] RLTC_IDX_L2_PER_HI  = 32'h0B0000DA;
  localparam logic [31:0] RLTC_IDX_L2_CNT_LO  = 32'h0B0000DC;
  localparam logic [31:0] RLTC_IDX_L2_CNT_HI  = 32'h0B0000DE;
  localparam logic [31:0] RLTC_IDX_TK_PER_LO  = 32'h0B0001C0;
  localparam logic [31:0] RLTC_IDX_TK_PER_HI  = 32'h0B0001C2;
  localparam logic [31:0] RLTC_IDX_TK_CNT_LO  = 32'h0B0001C4;
  localparam logic [31:0] RLTC_IDX_TK_CNT_HI  = 32'h0B0001C6;
  localparam logic [31:0] RLTC_IDX_IRQ_STAT   = 32'h0B0001DE;
  localparam logic [31:0] RLTC_IDX_IRQ_CLR    = 32'h0B0001E8;
  localparam logic [31:0] RLTC_IDX_IRQ_EN     = 32'h0B0001EA;

  // Interrupt status bit positions
  localparam int unsigned RLTC_BIT_LONG2 = 2;
  localparam int unsigned RLTC_BIT_TICK  = 3;

  // Reset values
  localparam logic [15:0] RLTC_RST_REG16 = 16'h0000;
  localparam logic [31:0] RLTC_RST_PRDATA = 32'h00000000;

  function automatic logic [31:0] rltc_byte_addr(input logic [31:0] idx);
    rltc_byte_addr = {idx[29:0], 2'b00};
  endfunction : rltc_byte_addr

endpackage : rltc_pkg

/* src/rltc_down_counter.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Periodic reload down-counter
// ****************************************************************
module rltc_down_counter #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] period,
  input  wire logic         step,
  output logic      [W-1:0] count_r,
  output logic              hit_r
);

  logic [W-1:0] period_r;
  logic [W-1:0] count_nxt;
  logic         hit_nxt;
  wire          stopped  = (period_r == '0);
  wire          at_one   = (count_r == W'(1));
  wire          at_floor = (count_r == '0) | at_one;

  // A zero period parks the unit at zero; a fresh period restarts it
  assign count_nxt = load                 ? period :
                     stopped              ? '0 :
                     (step & at_floor)    ? period_r :
                     step                 ? count_r - W'(1) :
                                            count_r;

  assign hit_nxt = step & ~load & ~stopped & at_one;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_r <= '0;
      count_r  <= '0;
      hit_r    <= 1'b0;
    end else begin
      if (load) begin
        period_r <= period;
      end
      count_r <= count_nxt;
      hit_r   <= hit_nxt;
    end
  end

endmodule : rltc_down_counter

`default_nettype wire

/* src/rltc_top.sv */
// Functional notes
// - The live 24-bit long2 count reads as bits 15:0 low and bits 23:16 in the high low byte.
// - Reserved bits are written as zero by software and always read back as zero.
// - The long2 counter steps down once per 32.768 kHz time-base period.
// - The long2 countdown starts from the period software programmed.
// - At one the long2 counter raises its interrupt, reloads and keeps counting.
// - The 25-bit tick period sits as bits 15:0 low and bits 24:16 in high bits 8:0, read/write.
// - The tick countdown starts from the period software wrote.
// - A new tick period takes effect only once both halves have been written.
// - An all-zero tick period stops the tick unit.
// - The live 25-bit tick count reads as bits 15:0 low and bits 24:16 in high bits 8:0.
// - At one the tick counter raises its interrupt, reloads and keeps counting.
// - A long2 period applies after both halves are written, and zero stops that unit.
// - The long2 interrupt latches as status bit 2 and clears by writing one to it.
// - The tick interrupt latches as status bit 3 and clears by writing one to it.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module rltc_top
  import rltc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rtc_domain_reset_n,
  input  wire logic        rtc_32k_tick,
  input  wire logic        tick_counter_enable,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ****************************************************************
  // Reset domains
  // ****************************************************************
  // The long2 side lives on the RTC reset alone so that a system
  // reset leaves the time base running; all else sees both resets.
  wire any_rst_n = presetn & rtc_domain_reset_n;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire setup_ph = psel & ~penable;
  wire wr_en    = psel & penable & pwrite & pready;

  wire sel_l2_plo = (paddr == rltc_byte_addr(RLTC_IDX_L2_PER_LO));
  wire sel_l2_phi = (paddr == rltc_byte_addr(RLTC_IDX_L2_PER_HI));
  wire sel_l2_clo = (paddr == rltc_byte_addr(RLTC_IDX_L2_CNT_LO));
  wire sel_l2_chi = (paddr == rltc_byte_addr(RLTC_IDX_L2_CNT_HI));
  wire sel_tk_plo = (paddr == rltc_byte_addr(RLTC_IDX_TK_PER_LO));
  wire sel_tk_phi = (paddr == rltc_byte_addr(RLTC_IDX_TK_PER_HI));
  wire sel_tk_clo = (paddr == rltc_byte_addr(RLTC_IDX_TK_CNT_LO));
  wire sel_tk_chi = (paddr == rltc_byte_addr(RLTC_IDX_TK_CNT_HI));
  wire sel_stat   = (paddr == rltc_byte_addr(RLTC_IDX_IRQ_STAT));
  wire sel_clr    = (paddr == rltc_byte_addr(RLTC_IDX_IRQ_CLR));
  wire sel_en     = (paddr == rltc_byte_addr(RLTC_IDX_IRQ_EN));

  wire addr_hit = sel_l2_plo | sel_l2_phi | sel_l2_clo | sel_l2_chi |
                  sel_tk_plo | sel_tk_phi | sel_tk_clo | sel_tk_chi |
                  sel_stat   | sel_clr    | sel_en;

  wire wr_l2_plo = wr_en & sel_l2_plo;
  wire wr_l2_phi = wr_en & sel_l2_phi;
  wire wr_tk_plo = wr_en & sel_tk_plo;
  wire wr_tk_phi = wr_en & sel_tk_phi;
  wire wr_en_reg = wr_en & sel_en;
  wire wr_w1c    = wr_en & (sel_stat | sel_clr);

  // ****************************************************************
  // Long2 period staging
  // ****************************************************************
  logic [15:0]             l2_stage_lo_r;
  logic [RLTC_L2_HI_W-1:0] l2_stage_hi_r;
  logic                    l2_lo_seen_r;
  logic                    l2_hi_seen_r;

  // The pair is committed by whichever half completes it
  wire l2_commit = (l2_lo_seen_r | wr_l2_plo) &
                   (l2_hi_seen_r | wr_l2_phi) &
                   (wr_l2_plo | wr_l2_phi);

  wire [RLTC_LONG2_W-1:0] l2_period_new = {
    (wr_l2_phi ? pwdata[RLTC_L2_HI_W-1:0] : l2_stage_hi_r),
    (wr_l2_plo ? pwdata[15:0] : l2_stage_lo_r)
  };

  always_ff @(posedge pclk or negedge rtc_domain_reset_n) begin
    if (!rtc_domain_reset_n) begin
      l2_stage_lo_r <= RLTC_RST_REG16;
      l2_stage_hi_r <= '0;
      l2_lo_seen_r  <= 1'b0;
      l2_hi_seen_r  <= 1'b0;
    end else begin
      if (wr_l2_plo) begin
        l2_stage_lo_r <= pwdata[15:0];
      end
      if (wr_l2_phi) begin
        l2_stage_hi_r <= pwdata[RLTC_L2_HI_W-1:0];
      end
      l2_lo_seen_r <= ~l2_commit & (l2_lo_seen_r | wr_l2_plo);
      l2_hi_seen_r <= ~l2_commit & (l2_hi_seen_r | wr_l2_phi);
    end
  end

  // ****************************************************************
  // Long2 counter
  // ****************************************************************
  logic [RLTC_LONG2_W-1:0] long2_live_count;
  logic                    l2_hit;

  rltc_down_counter #(
    .W (RLTC_LONG2_W)
  ) u_long2 (
    .clk     (pclk),
    .rst_n   (rtc_domain_reset_n),
    .load    (l2_commit),
    .period  (l2_period_new),
    .step    (rtc_32k_tick),
    .count_r (long2_live_count),
    .hit_r   (l2_hit)
  );

  // ****************************************************************
  // Tick period staging
  // ****************************************************************
  logic [15:0]             tk_stage_lo_r;
  logic [RLTC_TK_HI_W-1:0] tk_stage_hi_r;
  logic                    tk_lo_seen_r;
  logic                    tk_hi_seen_r;

  wire tk_commit = (tk_lo_seen_r | wr_tk_plo) &
                   (tk_hi_seen_r | wr_tk_phi) &
                   (wr_tk_plo | wr_tk_phi);

  wire [RLTC_TICK_W-1:0] tk_period_new = {
    (wr_tk_phi ? pwdata[RLTC_TK_HI_W-1:0] : tk_stage_hi_r),
    (wr_tk_plo ? pwdata[15:0] : tk_stage_lo_r)
  };

  always_ff @(posedge pclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      tk_stage_lo_r <= RLTC_RST_REG16;
      tk_stage_hi_r <= '0;
      tk_lo_seen_r  <= 1'b0;
      tk_hi_seen_r  <= 1'b0;
    end else begin
      if (wr_tk_plo) begin
        tk_stage_lo_r <= pwdata[15:0];
      end
      if (wr_tk_phi) begin
        tk_stage_hi_r <= pwdata[RLTC_TK_HI_W-1:0];
      end
      tk_lo_seen_r <= ~tk_commit & (tk_lo_seen_r | wr_tk_plo);
      tk_hi_seen_r <= ~tk_commit & (tk_hi_seen_r | wr_tk_phi);
    end
  end

  // ****************************************************************
  // Tick counter
  // ****************************************************************
  logic [RLTC_TICK_W-1:0] tick_live_count;
  logic                   tk_hit;

  // A committed zero period parks the unit until a nonzero one arrives
  rltc_down_counter #(
    .W (RLTC_TICK_W)
  ) u_tick (
    .clk     (pclk),
    .rst_n   (any_rst_n),
    .load    (tk_commit),
    .period  (tk_period_new),
    .step    (tick_counter_enable),
    .count_r (tick_live_count),
    .hit_r   (tk_hit)
  );

  // ****************************************************************
  // Interrupt status, clear and enable
  // ****************************************************************
  logic       long2_irq_flag_r;
  logic       tick_irq_flag_r;
  logic [1:0] irq_en_r;

  wire clr_l2 = wr_w1c & pwdata[RLTC_BIT_LONG2];
  wire clr_tk = wr_w1c & pwdata[RLTC_BIT_TICK];

  // A hit in the same cycle as a clear keeps the flag set
  wire long2_flag_nxt = l2_hit | (long2_irq_flag_r & ~clr_l2);
  wire tick_flag_nxt  = tk_hit | (tick_irq_flag_r & ~clr_tk);

  wire [1:0] irq_en_nxt = wr_en_reg ?
                          {pwdata[RLTC_BIT_TICK], pwdata[RLTC_BIT_LONG2]} :
                          irq_en_r;

  // The long2 flag survives a system reset along with its counter
  always_ff @(posedge pclk or negedge rtc_domain_reset_n) begin
    if (!rtc_domain_reset_n) begin
      long2_irq_flag_r <= 1'b0;
    end else begin
      long2_irq_flag_r <= long2_flag_nxt;
    end
  end

  always_ff @(posedge pclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      tick_irq_flag_r <= 1'b0;
      irq_en_r        <= 2'b00;
    end else begin
      tick_irq_flag_r <= tick_flag_nxt;
      irq_en_r        <= irq_en_nxt;
    end
  end

  wire irq_nxt = (long2_flag_nxt & irq_en_nxt[0]) |
                 (tick_flag_nxt  & irq_en_nxt[1]);

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire [15:0] stat_word = {
    12'h000, tick_irq_flag_r, long2_irq_flag_r, 2'b00
  };

  wire [15:0] en_word = {12'h000, irq_en_r, 2'b00};

  // Narrow fields are zero-extended so reserved bits read as zero
  wire [15:0] rd_word =
    sel_l2_plo ? l2_stage_lo_r :
    sel_l2_phi ? {8'h00, l2_stage_hi_r} :
    sel_l2_clo ? long2_live_count[15:0] :
    sel_l2_chi ? {8'h00, long2_live_count[RLTC_LONG2_W-1:16]} :
    sel_tk_plo ? tk_stage_lo_r :
    sel_tk_phi ? {7'h00, tk_stage_hi_r} :
    sel_tk_clo ? tick_live_count[15:0] :
    sel_tk_chi ? {7'h00, tick_live_count[RLTC_TICK_W-1:16]} :
    sel_stat   ? stat_word :
    sel_en     ? en_word :
                 16'h0000;

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // No wait state: data and status are caught in the setup cycle,
  // which keeps every bus output on a flop without adding a cycle.
  wire        pready_nxt  = setup_ph;
  wire        pslverr_nxt = setup_ph & ~addr_hit;
  wire [31:0] prdata_nxt  = (setup_ph & ~pwrite & addr_hit) ?
                            {16'h0000, rd_word} : RLTC_RST_PRDATA;

  always_ff @(posedge pclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RLTC_RST_PRDATA;
      irq     <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
      irq     <= irq_nxt;
    end
  end

endmodule : rltc_top

`default_nettype wire

/* verif/rltc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host side APB master
// ****************************************
module rltc_host (
  input  wire logic        pclk,
  output logic      [31:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr = 32'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // At least one idle cycle between transfers; the wait is bounded
  task automatic xfer(
    input  logic        wr,
    input  logic [31:0] idx,
    input  logic [31:0] wd,
    output logic [31:0] rd,
    output logic        err,
    output logic        hung
  );
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= {idx[29:0], 2'h0};
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hung = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rltc_host
`default_nettype wire

/* verif/rltc_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module rltc_props
  import rltc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rtc_domain_reset_n,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        irq
);
  function automatic logic [31:0] ba(input logic [31:0] i);
    return {i[29:0], 2'h0};
  endfunction : ba
  wire logic rd_ans = pready && !pwrite;
  wire logic a_tkh = paddr == ba(RLTC_IDX_TK_CNT_HI) || paddr == ba(RLTC_IDX_TK_PER_HI);
  wire logic a_l2h = paddr == ba(RLTC_IDX_L2_CNT_HI) || paddr == ba(RLTC_IDX_L2_PER_HI);
  wire logic a_lo = paddr == ba(RLTC_IDX_L2_PER_LO) || paddr == ba(RLTC_IDX_L2_CNT_LO)
    || paddr == ba(RLTC_IDX_TK_PER_LO) || paddr == ba(RLTC_IDX_TK_CNT_LO);
  wire logic a_irq = paddr == ba(RLTC_IDX_IRQ_STAT) || paddr == ba(RLTC_IDX_IRQ_CLR)
    || paddr == ba(RLTC_IDX_IRQ_EN);
  wire logic hit = a_tkh || a_l2h || a_lo || a_irq;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !rtc_domain_reset_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_en_off;
    psel && penable && pready && pwrite && paddr == ba(RLTC_IDX_IRQ_EN) && pwdata[3:2] == 2'h0;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no answer");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_on_unmapped: assert property (pready |-> pslverr == !hit) else $error("bad error");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_upper_half_zero: assert property (rd_ans |-> prdata[31:16] == 16'h0)
    else $error("upper bits set");
  a_long2_high_zero: assert property (rd_ans && a_l2h |-> prdata[15:8] == 8'h0)
    else $error("long2 reserved set");
  a_tick_high_zero: assert property (rd_ans && a_tkh |-> prdata[15:9] == 7'h0)
    else $error("tick reserved set");
  a_irq_mask_off: assert property (s_en_off |-> ##[1:2] !irq)
    else $error("masked irq high");
endmodule : rltc_props
bind rltc_top rltc_props rltc_props_inst (.pclk(pclk), .presetn(presetn),
  .rtc_domain_reset_n(rtc_domain_reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module testbench
  import rltc_pkg::*;
;
  logic        pclk, presetn, rtc_n, t32k, tken, err, hung, irq, psel, pen, pwr, prdy, perr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  int          bad_count, n_checks;
  rltc_top rltc_top_inst (.pclk(pclk), .presetn(presetn), .rtc_domain_reset_n(rtc_n),
    .rtc_32k_tick(t32k), .tick_counter_enable(tken), .paddr(paddr), .psel(psel),
    .penable(pen), .pwrite(pwr), .pwdata(pwdata), .prdata(prdata), .pready(prdy),
    .pslverr(perr), .irq(irq));
  rltc_host rltc_host_inst (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(pen),
    .pwrite(pwr), .pwdata(pwdata), .prdata(prdata), .pready(prdy), .pslverr(perr));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] idx, input logic [31:0] wd);
    rltc_host_inst.xfer(w, idx, wd, rdat, err, hung);
    if (hung) begin
      bad_count++;
      results();
    end
  endtask : bus
  task automatic rchk(input logic [31:0] idx, input logic [31:0] e, input string nm);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, rdat);
  endtask : rchk
  task automatic step(input logic lng, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (lng) t32k <= 1'b1;
      else tken <= 1'b1;
      @(posedge pclk);
      t32k <= 1'b0;
      tken <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : step
  task automatic rst(input logic rtc);
    @(posedge pclk);
    if (rtc) rtc_n <= 1'b0;
    else presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    rtc_n <= 1'b1;
    presetn <= 1'b1;
  endtask : rst
  function automatic logic [31:0] exp_cnt(input logic [31:0] p, input int k);
    logic [31:0] c;
    c = p;
    repeat (k)
      c = (c <= 32'h1) ? p : c - 32'h1;
    return c;
  endfunction : exp_cnt
  // Same sequence for both units; only indices, width, step input, status bit and clear register differ
  task automatic unit(input logic lng);
    logic [31:0] plo, phi, clo, chi, sb, p, e;
    plo = lng ? RLTC_IDX_L2_PER_LO : RLTC_IDX_TK_PER_LO;
    phi = lng ? RLTC_IDX_L2_PER_HI : RLTC_IDX_TK_PER_HI;
    clo = lng ? RLTC_IDX_L2_CNT_LO : RLTC_IDX_TK_CNT_LO;
    chi = lng ? RLTC_IDX_L2_CNT_HI : RLTC_IDX_TK_CNT_HI;
    sb = lng ? 32'h4 : 32'h8;
    p = ($urandom & (lng ? 32'hFFFFFF : 32'h1FFFFFF)) | 32'h10000;
    bus(1'b1, plo, p & 32'hFFFF);
    rchk(clo, 32'h0, "count half written");
    bus(1'b1, phi, p >> 16);
    rchk(phi, p >> 16, "period high");
    step(lng, 2);
    e = exp_cnt(p, 2);
    rchk(clo, e & 32'hFFFF, "count low");
    rchk(chi, e >> 16, "count high");
    // Periods of 1 to 4 with a zero high half are off limits to software
    p = 32'h5 + ($urandom % 5);
    bus(1'b1, phi, 32'h0);
    bus(1'b1, plo, p);
    step(lng, p - 1);
    rchk(clo, 32'h1, "count at one");
    rchk(RLTC_IDX_IRQ_STAT, 32'h0, "status early");
    step(lng, 1);
    rchk(RLTC_IDX_IRQ_STAT, sb, "status set");
    rchk(clo, p, "reloaded");
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, RLTC_IDX_IRQ_EN, 32'h0);
    // The interrupt output flips at the write edge itself; look one edge later
    @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, RLTC_IDX_IRQ_EN, 32'hC);
    bus(1'b1, lng ? RLTC_IDX_IRQ_CLR : RLTC_IDX_IRQ_STAT, sb);
    rchk(RLTC_IDX_IRQ_STAT, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, phi, 32'h0);
    bus(1'b1, plo, 32'h0);
    step(lng, 2);
    rchk(clo, 32'h0, "stopped");
  endtask : unit
  initial begin
    {presetn, rtc_n, t32k, tken} = 4'h0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h60B7A716));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rtc_n <= 1'b1;
    rchk(RLTC_IDX_TK_PER_HI, 32'h0, "reset value");
    rchk(RLTC_IDX_L2_CNT_HI, 32'h0, "reset value");
    bus(1'b0, 32'h0B000100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    bus(1'b1, RLTC_IDX_TK_CNT_LO, 32'hFFFF);
    rchk(RLTC_IDX_TK_CNT_LO, 32'h0, "read-only count");
    bus(1'b1, RLTC_IDX_IRQ_EN, 32'hC);
    unit(1'b0);
    unit(1'b1);
    bus(1'b1, RLTC_IDX_TK_PER_LO, 32'h5);
    bus(1'b1, RLTC_IDX_L2_PER_HI, 32'h0);
    bus(1'b1, RLTC_IDX_L2_PER_LO, 32'h9);
    step(1'b1, 1);
    rst(1'b0);
    rchk(RLTC_IDX_L2_CNT_LO, 32'h8, "long2 kept");
    rchk(RLTC_IDX_TK_PER_LO, 32'h0, "tick cleared");
    rst(1'b1);
    rchk(RLTC_IDX_L2_CNT_LO, 32'h0, "long2 cleared");
    results();
  end
endmodule : testbench
`default_nettype wire
